/* inc/ilpm_pkg.sv */
// Types shared by the interrupt level and priority map files.
// Assumes ilpm_regs.svh is on the include path.
`include "ilpm_regs.svh"

package ilpm_pkg;
  typedef logic [2:0] ilpm_level_t;
  typedef logic [6:0] ilpm_vec_t;
  typedef logic [`ILPM_CELLS-1:0][6:0] ilpm_cell_vec_t;
  typedef logic [`ILPM_LEVELS-1:0][6:0] ilpm_level_vec_t;
endpackage

/* inc/ilpm_regs.svh */
// Constants of the interrupt level and priority map: grid shape, vectors,
// register byte offsets and reset values.
// Assumes a 32-bit AHB-Lite slave port with one register per aligned word.
`ifndef ILPM_REGS_SVH
`define ILPM_REGS_SVH

// Grid shape
`define ILPM_LEVELS 7
`define ILPM_SLOTS 9
`define ILPM_CELLS 63
`define ILPM_SOURCES 30
`define ILPM_LEVEL_TOP 3'h7

// Vector numbers
`define ILPM_VEC_SOURCE_BASE 7'h40
`define ILPM_VEC_FORCE_BASE 7'h60
`define ILPM_VEC_SPURIOUS 7'h18
`define ILPM_VEC_NONE 7'h00

// Grid cells of the two remappable slots at level 6
`define ILPM_CELL_REMAP_TOP 6'h35
`define ILPM_CELL_REMAP_SECOND 6'h34

// Cell of each fixed source, source 29 first, source 0 last; cell = (level-1)*9+slot
`define ILPM_SRC_CELL_TABLE {6'h01, 6'h02, 6'h03, 6'h05, 6'h06, 6'h07, 6'h08, 6'h0b, 6'h0c, 6'h0e, \
  6'h0f, 6'h17, 6'h18, 6'h19, 6'h1a, 6'h1e, 6'h20, 6'h21, 6'h22, 6'h23, 6'h25, 6'h2a, 6'h2b, 6'h2c, \
  6'h2e, 6'h30, 6'h32, 6'h33, 6'h39, 6'h3a}

// Shared sources of the merged instance pairs
`define ILPM_SRC_TWO_WIRE 15
`define ILPM_SRC_KEYPAD 16
`define ILPM_SRC_COMPARATOR 18

// Force codes written to the set and clear registers
`define ILPM_FORCE_CODE_FIRST 6'h20
`define ILPM_FORCE_CODE_LAST 6'h26

// Register byte offsets
`define ILPM_OFS_FORCE 8'h00
`define ILPM_OFS_FORCE_SET 8'h04
`define ILPM_OFS_FORCE_CLR 8'h08
`define ILPM_OFS_REMAP_TOP 8'h0c
`define ILPM_OFS_REMAP_SECOND 8'h10
`define ILPM_OFS_LEVEL_MASK 8'h14
`define ILPM_OFS_SW_ACK 8'h18
`define ILPM_OFS_CORE_STATE 8'h1c
`define ILPM_OFS_STATUS 8'h20
`define ILPM_OFS_IRQ_MASK 8'h24
`define ILPM_OFS_LEVEL_ACK1 8'h40
`define ILPM_OFS_LEVEL_ACK7 8'h58

// Reset values
`define ILPM_RST_FORCE 7'h00
`define ILPM_RST_REMAP 5'h00
`define ILPM_RST_LEVEL_MASK 6'h3f
`define ILPM_RST_STATUS 2'h0
`define ILPM_RST_IRQ_MASK 2'h0

// Status bits
`define ILPM_ST_NMI 0
`define ILPM_ST_SPURIOUS 1

// Bus encodings
`define ILPM_HSIZE_WORD 3'h2
`define ILPM_HRESP_OKAY 1'h0

`endif

/* sim/ilpm_core_model.sv */
// Core side model: counts the non-maskable entries that the core takes.
// Assumes the entry pulse is one cycle wide and on the same clock.
`timescale 1ns/1ns
module ilpm_core_model (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic nmi_i,
  output logic [7:0] nmi_count_o
);
  // Each pulse is one taken entry, so a stuck pulse shows as a large count
  always_ff @(posedge clock_i or negedge rstn_i)
    if (!rstn_i)
      nmi_count_o <= 8'h00;
    else if (nmi_i)
      nmi_count_o <= nmi_count_o + 8'h01;
endmodule

/* sim/ilpm_properties.sv */
// Checker of the level and priority map: core outputs and bus wait states.
// Assumes it is bound to ilpm_top and sees only its ports.
`timescale 1ns/1ns
module ilpm_checker (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ext_pin_request_i,
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [2:0] core_level_o,
  input wire logic [6:0] core_vector_o,
  input wire logic nmi_pulse_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  // Transfer taken at this edge
  logic take;
  assign take = hsel_i && htrans_i[1] && hready_i;
  read_wait_a: assert property (take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read wait state wrong");
  write_nowait_a: assert property (take && hwrite_i |=> hreadyout_o)
    else $error("write stalled");
  // Pulse and level are loaded on the same edge, so they show together
  nmi_entry_a: assert property (core_level_o == 3'h7 && $past(core_level_o) != 3'h7 |-> nmi_pulse_o)
    else $error("no pulse on entry to top level");
  nmi_cause_a: assert property (nmi_pulse_o |-> core_level_o == 3'h7 && $past(core_level_o) != 3'h7)
    else $error("pulse without entry");
  resp_okay_a: assert property (hresp_o == 1'b0)
    else $error("bus response not okay");
  // Synchroniser plus output register fit well inside five cycles
  pin_wins_a: assert property (ext_pin_request_i [*5] |-> core_level_o == 3'h7 && core_vector_o == 7'h40)
    else $error("pin request not winning");
  none_pair_a: assert property ((core_level_o == 3'h0) == (core_vector_o == 7'h00))
    else $error("level and vector disagree");
  top_vector_a: assert property (core_level_o == 3'h7 |-> core_vector_o inside {7'h40, 7'h41, 7'h60})
    else $error("bad top level vector");
  vector_range_a: assert property (core_vector_o != 7'h00 |-> core_vector_o inside {[7'h40:7'h66]})
    else $error("core vector out of range");
endmodule

bind ilpm_top ilpm_checker ilpm_checker_inst (.clock_i(clock_i), .rstn_i(rstn_i),
  .ext_pin_request_i(ext_pin_request_i), .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .core_level_o(core_level_o),
  .core_vector_o(core_vector_o), .nmi_pulse_o(nmi_pulse_o));

/* sim/testbench.sv */
// Self-checking bench of the level and priority map with a core model.
// Assumes ilpm_regs.svh on the include path; the slave alone drives hready.
`timescale 1ns/1ns
`include "ilpm_regs.svh"
module testbench;
  typedef struct {int k; logic [31:0] v;} ilpm_note_t;
  logic clock_i = 0, rstn_i = 0, ext = 0, hsel = 0, hwrite = 0, look = 0, hrdy, hresp, nmi, irq;
  logic [29:1] periph = '0;
  logic [1:0] tw = 0, kp = 0, cp = 0, htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [2:0] hsize = `ILPM_HSIZE_WORD, lvl;
  logic [6:0] vec;
  logic [7:0] nmi_count;
  ilpm_note_t q[$], cur;
  int err_count = 0, n_checks = 0;

  always #50 clock_i = ~clock_i;

  ilpm_top ilpm_top_inst (.clock_i(clock_i), .rstn_i(rstn_i), .ext_pin_request_i(ext),
    .periph_request_i(periph), .two_wire_pair_request_i(tw), .keypad_pair_request_i(kp),
    .comparator_pair_request_i(cp), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
    .hreadyout_o(hrdy), .hresp_o(hresp), .core_level_o(lvl), .core_vector_o(vec),
    .nmi_pulse_o(nmi), .irq_o(irq));
  ilpm_core_model ilpm_core_model_inst (.clock_i(clock_i), .rstn_i(rstn_i), .nmi_i(nmi),
    .nmi_count_o(nmi_count));

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] e, input logic [31:0] a);
    n_checks++;
    if (e !== a)
    begin
      err_count++;
      $display("ERROR at %0t expected %h got %h", $time, e, a);
    end
  endtask
  // One compare per kind of result
  task automatic cmp_core(input logic [31:0] e); cmp(e, {22'h0, lvl, vec}); endtask
  task automatic cmp_data(input logic [31:0] e); cmp(e, hrdata); endtask
  task automatic cmp_irq(input logic [31:0] e); cmp(e, {31'h0, irq}); endtask
  task automatic cmp_count(input logic [31:0] e); cmp(e, {24'h0, nmi_count}); endtask

  // Ready is judged at the falling edge, as nothing moves between then and the sampling edge
  task automatic wait_rdy;
    int i = 0;
    @(negedge clock_i);
    while (hrdy !== 1'b1)
    begin
      if (++i > 50)
      begin
        err_count++;
        finish_test;
      end
      @(negedge clock_i);
    end
    @(posedge clock_i);
  endtask

  // One single word transfer, address phase then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    wait_rdy;
  endtask

  // Settle, then leave a note for the watcher
  task automatic note(input int k, input logic [31:0] v);
    repeat (2) @(posedge clock_i);
    q.push_back('{k, v});
    look <= 1'b1;
    @(posedge clock_i);
    look <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    note(1, e);
  endtask

  function automatic logic [2:0] lvl_of(input int s);
    return s < 2 ? 3'h7 : s < 6 ? 3'h6 : s < 10 ? 3'h5 : s < 15 ? 3'h4 : s < 19 ? 3'h3 : s < 23 ? 3'h2 : 3'h1;
  endfunction

  // Watcher: oldest note against what the outputs show now
  always @(posedge clock_i)
    if (look)
    begin
      cur = q.pop_front();
      case (cur.k)
        0: cmp_core(cur.v);
        1: cmp_data(cur.v);
        2: cmp_irq(cur.v);
        default: cmp_count(cur.v);
      endcase
    end

  initial
  begin
    int s;
    int k;
    logic [29:1] m;
    void'($urandom(32'h8d65_0332));
    repeat (8) @(posedge clock_i);
    rstn_i <= 1'b1;
    @(posedge clock_i);
    for (s = 1; s < 30; s++)
    begin
      m = '0;
      m[s] = 1'b1;
      periph <= m;
      note(0, {lvl_of(s), 7'h40 + 7'(s)});
    end
    periph <= '0;
    for (k = 0; k < 6; k++)
    begin
      {cp, kp, tw} <= 6'h01 << k;
      note(0, {3'h3, k < 2 ? 7'h4f : k < 4 ? 7'h50 : 7'h52});
    end
    {cp, kp, tw} <= 6'h00;
    $display("grid test done");
    for (k = 0; k < 20; k++)
    begin
      m = 29'($urandom);
      m[1] = 1'b0;
      if (m == '0)
        m[29] = 1'b1;
      periph <= m;
      for (s = 2; !m[s]; s++);
      note(0, {lvl_of(s), 7'h40 + 7'(s)});
    end
    periph <= '0;
    $display("priority test done");
    for (k = 0; k < 7; k++)
    begin
      bus(1'b1, `ILPM_OFS_FORCE_SET, 32'h0000_0020 + k);
      note(0, {3'(7 - k), 7'h60 + 7'(k)});
      rd(`ILPM_OFS_FORCE, 32'h0000_0001 << k);
      bus(1'b1, `ILPM_OFS_FORCE_CLR, 32'h0000_0020 + k);
      note(0, 32'h0);
    end
    bus(1'b1, `ILPM_OFS_FORCE_SET, 32'h0000_0027);
    rd(`ILPM_OFS_FORCE, 32'h0);
    m = '0;
    m[29] = 1'b1;
    periph <= m;
    bus(1'b1, `ILPM_OFS_FORCE_SET, 32'h0000_0026);
    note(0, {3'h1, 7'h5d});
    periph <= '0;
    note(0, {3'h1, 7'h66});
    bus(1'b1, `ILPM_OFS_FORCE_CLR, 32'h0000_0026);
    $display("force test done");
    m[2] = 1'b1;
    periph <= m;
    bus(1'b1, `ILPM_OFS_REMAP_TOP, 32'h0000_001d);
    note(0, {3'h6, 7'h5d});
    bus(1'b1, `ILPM_OFS_REMAP_TOP, 32'h0);
    bus(1'b1, `ILPM_OFS_REMAP_SECOND, 32'h0000_001d);
    note(0, {3'h6, 7'h5d});
    bus(1'b1, `ILPM_OFS_REMAP_SECOND, 32'h0);
    note(0, {3'h6, 7'h42});
    m[2] = 1'b0;
    periph <= m;
    bus(1'b1, `ILPM_OFS_LEVEL_MASK, 32'h0000_003e);
    note(0, 32'h0);
    rd(`ILPM_OFS_SW_ACK, 32'h0000_005d);
    bus(1'b1, `ILPM_OFS_LEVEL_MASK, 32'h0000_003f);
    periph <= '0;
    $display("remap and mask test done");
    rd(`ILPM_OFS_LEVEL_ACK1 + 8'h10, 32'h0000_0018);
    note(2, 32'h0);
    bus(1'b1, `ILPM_OFS_IRQ_MASK, 32'h0000_0002);
    note(2, 32'h1);
    bus(1'b1, `ILPM_OFS_STATUS, 32'h0000_0002);
    note(2, 32'h0);
    m = '0;
    m[6] = 1'b1;
    periph <= m;
    rd(`ILPM_OFS_LEVEL_ACK1 + 8'h10, 32'h0000_0046);
    rd(8'h30, 32'h0);
    $display("acknowledge test done");
    m[1] = 1'b1;
    periph <= m;
    ext <= 1'b1;
    repeat (2) @(posedge clock_i);
    note(0, {3'h7, 7'h40});
    ext <= 1'b0;
    repeat (2) @(posedge clock_i);
    note(0, {3'h7, 7'h41});
    periph <= '0;
    note(3, 32'h3);
    rd(`ILPM_OFS_STATUS, 32'h1);
    bus(1'b1, `ILPM_OFS_FORCE, 32'h0000_0041);
    rd(`ILPM_OFS_FORCE, 32'h0000_0041);
    rd(`ILPM_OFS_CORE_STATE, 32'h0000_0760);
    note(3, 32'h4);
    bus(1'b1, `ILPM_OFS_IRQ_MASK, 32'h0000_0003);
    note(2, 32'h1);
    bus(1'b1, `ILPM_OFS_FORCE, 32'h0);
    $display("pin test done");
    finish_test;
  end
endmodule

/* src/ilpm_rank.sv */
// Per-level ranking of the request grid: best active slot of each level.
// Assumes cell index (level-1)*9+slot, slot 8 ranking highest in a level.
`timescale 1ns/1ns
`include "ilpm_regs.svh"

module ilpm_rank (
  input wire logic [`ILPM_CELLS-1:0] cell_req_i,
  input wire ilpm_pkg::ilpm_cell_vec_t cell_vec_i,
  output logic [`ILPM_LEVELS-1:0] level_hit_o,
  output ilpm_pkg::ilpm_level_vec_t level_vec_o
);

  for (genvar l = 0; l < `ILPM_LEVELS; l++)
  begin : g_level
    logic hit;
    ilpm_pkg::ilpm_vec_t vec;

    // Ascending scan, so the highest occupied slot is the last one kept
    always_comb
    begin
      hit = 1'b0;
      vec = `ILPM_VEC_NONE;
      for (int s = 0; s < `ILPM_SLOTS; s++)
      begin
        if (cell_req_i[l * `ILPM_SLOTS + s])
        begin
          hit = 1'b1;
          vec = cell_vec_i[l * `ILPM_SLOTS + s];
        end
      end
    end

    assign level_hit_o[l] = hit;
    assign level_vec_o[l] = vec;
  end

endmodule

/* src/ilpm_top.sv */
// Interrupt level and priority map: request grid, ranking, core level and
// vector, forcing, remapping, acknowledge reads, AHB-Lite register slave.
// Assumes one clock; peripheral requests come from logic on this clock,
// the external pin request comes from outside and is synchronised here.
//
// Function
// - Seven levels of nine slots, sparsely occupied
// - Higher level wins, then higher slot
// - Level 1 slot 0 ranks lowest
// - Pin vector 64 mid, low-voltage 65
// - Fixed source vector is source plus 64
// - Forced request per level, vectors 96-102
// - Two level 6 remap cells, source vector
// - Remap and force cells only via registers
// - Paired instances share one source vector
// - Empty level acknowledge returns spurious 24
// - Level 7 unmaskable edge, others maskable
`timescale 1ns/1ns
`include "ilpm_regs.svh"

module ilpm_top (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ext_pin_request_i,
  input wire logic [`ILPM_SOURCES-1:1] periph_request_i,
  input wire logic [1:0] two_wire_pair_request_i,
  input wire logic [1:0] keypad_pair_request_i,
  input wire logic [1:0] comparator_pair_request_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [2:0] core_level_o,
  output logic [6:0] core_vector_o,
  output logic nmi_pulse_o,
  output logic irq_o
);

  localparam logic [`ILPM_SOURCES*6-1:0] SRC_CELL = `ILPM_SRC_CELL_TABLE;

  logic pin_meta_q;
  logic pin_sync_q;
  logic [6:0] forced_level_request_q; // bit 0 is level 7, bit 6 is level 1
  logic [4:0] level6_top_remap_select_q;
  logic [4:0] level6_second_remap_select_q;
  logic [5:0] level_mask_q;
  logic [1:0] status_q;
  logic [1:0] irq_mask_q;
  logic [2:0] core_level_q;
  logic [6:0] core_vector_q;
  logic nmi_pulse_q;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] addr_q;
  logic [31:0] hrdata_q;
  logic [`ILPM_SOURCES-1:0] source_req;
  logic [`ILPM_CELLS-1:0] cell_req;
  ilpm_pkg::ilpm_cell_vec_t cell_vec;
  logic [`ILPM_LEVELS-1:0] level_hit;
  ilpm_pkg::ilpm_level_vec_t level_vec;
  logic [`ILPM_LEVELS-1:0] level_enable;
  logic [9:0] core_pick;
  logic [9:0] sw_pick;
  logic take;
  logic [1:0] status_set;
  logic [31:0] rd_mux;
  logic spurious_read;
  logic [2:0] ack_level;
  logic remap_top_valid;
  logic remap_second_valid;

  // Best enabled level and its vector, as {level, vector}; zero when none
  function automatic logic [9:0] pick(input logic [`ILPM_LEVELS-1:0] hit,
                                      input ilpm_pkg::ilpm_level_vec_t vec,
                                      input logic [`ILPM_LEVELS-1:0] en);
    logic [9:0] res;
    res = '0;
    for (int l = 0; l < `ILPM_LEVELS; l++)
    begin
      if (hit[l] && en[l])
      begin
        res = {3'(l + 1), vec[l]};
      end
    end
    return res;
  endfunction

  // Pin request is asynchronous, two flops before any use
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end
    else
    begin
      pin_meta_q <= ext_pin_request_i;
      pin_sync_q <= pin_meta_q;
    end
  end

  // Source requests with the instance pairs merged onto their shared source
  always_comb
  begin
    source_req = {periph_request_i, pin_sync_q};
    source_req[`ILPM_SRC_TWO_WIRE] = periph_request_i[`ILPM_SRC_TWO_WIRE] | (|two_wire_pair_request_i);
    source_req[`ILPM_SRC_KEYPAD] = periph_request_i[`ILPM_SRC_KEYPAD] | (|keypad_pair_request_i);
    source_req[`ILPM_SRC_COMPARATOR] = periph_request_i[`ILPM_SRC_COMPARATOR] | (|comparator_pair_request_i);
  end

  // Select value zero or out of range leaves the remap cell empty
  assign remap_top_valid = level6_top_remap_select_q != `ILPM_RST_REMAP &&
                           level6_top_remap_select_q < 5'(`ILPM_SOURCES);
  assign remap_second_valid = level6_second_remap_select_q != `ILPM_RST_REMAP &&
                              level6_second_remap_select_q < 5'(`ILPM_SOURCES);

  // Grid fill; cells not named here stay idle and never request
  always_comb
  begin
    cell_req = '0;
    cell_vec = '0;
    for (int s = 0; s < `ILPM_SOURCES; s++)
    begin
      // Only a live remap moves a source; a disabled select must not hide source 0
      if (!(remap_top_valid && 5'(s) == level6_top_remap_select_q) &&
          !(remap_second_valid && 5'(s) == level6_second_remap_select_q))
      begin
        cell_req[SRC_CELL[s * 6 +: 6]] = source_req[s];
      end
      cell_vec[SRC_CELL[s * 6 +: 6]] = `ILPM_VEC_SOURCE_BASE + 7'(s);
    end
    if (remap_top_valid)
    begin
      cell_req[`ILPM_CELL_REMAP_TOP] = source_req[level6_top_remap_select_q];
      cell_vec[`ILPM_CELL_REMAP_TOP] = `ILPM_VEC_SOURCE_BASE + 7'(level6_top_remap_select_q);
    end
    if (remap_second_valid)
    begin
      cell_req[`ILPM_CELL_REMAP_SECOND] = source_req[level6_second_remap_select_q];
      cell_vec[`ILPM_CELL_REMAP_SECOND] = `ILPM_VEC_SOURCE_BASE + 7'(level6_second_remap_select_q);
    end
    // Forced cells sit in slot 0; force bit i belongs to level 7-i
    for (int i = 0; i < `ILPM_LEVELS; i++)
    begin
      cell_req[(`ILPM_LEVELS - 1 - i) * `ILPM_SLOTS] = forced_level_request_q[i];
      cell_vec[(`ILPM_LEVELS - 1 - i) * `ILPM_SLOTS] = `ILPM_VEC_FORCE_BASE + 7'(i);
    end
  end

  ilpm_rank u_rank (
    .cell_req_i(cell_req),
    .cell_vec_i(cell_vec),
    .level_hit_o(level_hit),
    .level_vec_o(level_vec)
  );

  // Level 7 always counts; levels 1 to 6 pass the level mask
  assign level_enable = {1'b1, level_mask_q};
  assign core_pick = pick(level_hit, level_vec, level_enable);
  // Software acknowledge sees pending requests even when masked
  assign sw_pick = pick(level_hit, level_vec, {`ILPM_LEVELS{1'b1}});

  // Core level and vector follow the winner every cycle
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      core_level_q <= '0;
      core_vector_q <= `ILPM_VEC_NONE;
      nmi_pulse_q <= 1'b0;
    end
    else
    begin
      core_level_q <= core_pick[9:7];
      core_vector_q <= core_pick[6:0];
      // Level 7 is taken on the edge into it, so a held request fires once
      nmi_pulse_q <= (core_pick[9:7] == `ILPM_LEVEL_TOP) && (core_level_q != `ILPM_LEVEL_TOP);
    end
  end

  assign core_level_o = core_level_q;
  assign core_vector_o = core_vector_q;
  assign nmi_pulse_o = nmi_pulse_q;

  // Bus address phase is taken only while the bus is ready
  assign take = hsel_i && htrans_i[1] && hready_i;
  assign ack_level = 3'(((addr_q - `ILPM_OFS_LEVEL_ACK1) >> 2) + 8'h01);

  // Read mux; a level acknowledge of an empty level returns spurious
  always_comb
  begin
    rd_mux = '0;
    spurious_read = 1'b0;
    if (addr_q >= `ILPM_OFS_LEVEL_ACK1 && addr_q <= `ILPM_OFS_LEVEL_ACK7)
    begin
      if (level_hit[ack_level - 3'h1])
      begin
        rd_mux[6:0] = level_vec[ack_level - 3'h1];
      end
      else
      begin
        rd_mux[6:0] = `ILPM_VEC_SPURIOUS;
        spurious_read = 1'b1;
      end
    end
    else
    begin
      unique case (addr_q)
        `ILPM_OFS_FORCE: rd_mux[6:0] = forced_level_request_q;
        `ILPM_OFS_REMAP_TOP: rd_mux[4:0] = level6_top_remap_select_q;
        `ILPM_OFS_REMAP_SECOND: rd_mux[4:0] = level6_second_remap_select_q;
        `ILPM_OFS_LEVEL_MASK: rd_mux[5:0] = level_mask_q;
        `ILPM_OFS_SW_ACK: rd_mux[6:0] = sw_pick[6:0];
        `ILPM_OFS_CORE_STATE: rd_mux[10:0] = {core_level_q, 1'b0, core_vector_q};
        `ILPM_OFS_STATUS: rd_mux[1:0] = status_q;
        `ILPM_OFS_IRQ_MASK: rd_mux[1:0] = irq_mask_q;
        default: rd_mux = '0; // Unmapped and write-only offsets read zero
      endcase
    end
  end

  // Bus phase tracking; reads get one wait state so a preceding write is seen
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= '0;
      hrdata_q <= '0;
    end
    else
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      if (rd_pend_q)
      begin
        hrdata_q <= rd_mux;
      end
      if (take)
      begin
        // Upper address bits or a non-word size select nothing
        addr_q <= (haddr_i[31:8] == 24'h00_0000 && hsize_i == `ILPM_HSIZE_WORD) ? haddr_i[7:0] : 8'hfc;
        wr_pend_q <= hwrite_i;
        rd_pend_q <= !hwrite_i;
      end
    end
  end

  assign hreadyout_o = !rd_pend_q;
  assign hresp_o = `ILPM_HRESP_OKAY;
  assign hrdata_o = hrdata_q;

  // Force register: direct write, or set and clear by code
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      forced_level_request_q <= `ILPM_RST_FORCE;
    end
    else if (wr_pend_q)
    begin
      if (addr_q == `ILPM_OFS_FORCE)
      begin
        forced_level_request_q <= hwdata_i[6:0];
      end
      else if ((addr_q == `ILPM_OFS_FORCE_SET || addr_q == `ILPM_OFS_FORCE_CLR) &&
               hwdata_i[5:0] >= `ILPM_FORCE_CODE_FIRST && hwdata_i[5:0] <= `ILPM_FORCE_CODE_LAST)
      begin
        // Codes outside the range leave the register untouched
        forced_level_request_q[3'(hwdata_i[5:0] - `ILPM_FORCE_CODE_FIRST)] <=
          (addr_q == `ILPM_OFS_FORCE_SET);
      end
    end
  end

  // Remap selects, level mask and interrupt mask
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      level6_top_remap_select_q <= `ILPM_RST_REMAP;
      level6_second_remap_select_q <= `ILPM_RST_REMAP;
      level_mask_q <= `ILPM_RST_LEVEL_MASK;
      irq_mask_q <= `ILPM_RST_IRQ_MASK;
    end
    else if (wr_pend_q)
    begin
      unique case (addr_q)
        `ILPM_OFS_REMAP_TOP: level6_top_remap_select_q <= hwdata_i[4:0];
        `ILPM_OFS_REMAP_SECOND: level6_second_remap_select_q <= hwdata_i[4:0];
        `ILPM_OFS_LEVEL_MASK: level_mask_q <= hwdata_i[5:0];
        `ILPM_OFS_IRQ_MASK: irq_mask_q <= hwdata_i[1:0];
        default: level_mask_q <= level_mask_q;
      endcase
    end
  end

  // Sticky events; a new event beats a write-one clear in the same cycle
  always_comb
  begin
    status_set = '0;
    status_set[`ILPM_ST_NMI] = nmi_pulse_q;
    status_set[`ILPM_ST_SPURIOUS] = rd_pend_q && spurious_read;
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      status_q <= `ILPM_RST_STATUS;
    end
    else if (wr_pend_q && addr_q == `ILPM_OFS_STATUS)
    begin
      status_q <= (status_q & ~hwdata_i[1:0]) | status_set;
    end
    else
    begin
      status_q <= status_q | status_set;
    end
  end

  assign irq_o = |(status_q & irq_mask_q);

endmodule
